// ==== hw/odc_pkg.sv ====
// Package for the counter output drive control block
package odc_pkg;
	localparam int ODC_AW = 4;
	localparam logic [3:0] ODC_OFF_CTRL = 4'h0;
	localparam logic [3:0] ODC_OFF_STAT = 4'h4;
	localparam logic [15:0] ODC_CTRL_RESET = 16'h0000;
	// Fields of output n sit at bit n*4
	localparam int ODC_FLD_STRIDE = 4;
	localparam int ODC_FLD_FORCE = 0;
	localparam int ODC_FLD_ENABLE = 1;
	localparam int ODC_FLD_KEEP = 2;
	localparam int ODC_FLD_UNUSED = 3;
	localparam int ODC_NUM_OUT = 2;
	localparam logic [1:0] ODC_RESP_OKAY = 2'b00;
	localparam logic [1:0] ODC_RESP_SLVERR = 2'b10;
endpackage : odc_pkg

// ==== hw/odc_top.sv ====
// Output drive control word with AXI4-Lite access and output gating
// Notes on behaviour
// - Output 0 keep-local set: stays counter-driven on loss
// - Keep-local clear: enable cleared on bus loss
// - Force and enable set: output on
// - Force clear: compare or pulse drive rules
// - Enable set permits any turn-on source
// - Enable clear holds output off always
// - Output 1 keep-local behaves like output 0
// - Output 0 force bit 0, enable bit 1
module odc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [odc_pkg::ODC_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [odc_pkg::ODC_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bus_loss_pin,
	input wire logic [odc_pkg::ODC_NUM_OUT-1:0] counter_drive,
	output logic [odc_pkg::ODC_NUM_OUT-1:0] out_pin
);
	import odc_pkg::*;

	logic [15:0] ctrl;
	logic loss_meta;
	logic loss_sync;
	logic loss_prev;
	logic aw_held;
	logic w_held;
	logic [ODC_AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// Address decode shared by the write and read paths
	function automatic logic odc_hit_ctrl(input logic [ODC_AW-1:0] addr);
		return addr == ODC_OFF_CTRL;
	endfunction : odc_hit_ctrl

	function automatic logic odc_hit_stat(input logic [ODC_AW-1:0] addr);
		return addr == ODC_OFF_STAT;
	endfunction : odc_hit_stat

	function automatic logic odc_hit_mapped(input logic [ODC_AW-1:0] addr);
		return odc_hit_ctrl(addr) | odc_hit_stat(addr);
	endfunction : odc_hit_mapped

	// Pin from the backplane side, outside our domain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loss_meta <= 1'b0;
			loss_sync <= 1'b0;
		end else begin
			loss_meta <= bus_loss_pin;
			loss_sync <= loss_meta;
		end
	end

	// Reset to the idle low level, so release of reset gives no false edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loss_prev <= 1'b0;
		end else begin
			loss_prev <= loss_sync;
		end
	end

	wire loss_event = loss_sync & ~loss_prev;

	// Write channel: address and data taken in either order
	// Held channels block until the response is taken
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire have_aw = aw_held | aw_take;
	wire have_w = w_held | w_take;
	wire [ODC_AW-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire wr_fire = have_aw & have_w & ~s_axi_bvalid;
	wire wr_ctrl = wr_fire & odc_hit_ctrl(wr_addr);
	// Status is read-only; a write to it is answered OKAY and dropped
	wire wr_ok = odc_hit_mapped(wr_addr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else begin
			if (aw_take) begin
				aw_addr <= s_axi_awaddr;
			end
			aw_held <= have_aw & ~wr_fire;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (w_take) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			w_held <= have_w & ~wr_fire;
		end
	end

	// Response stands until the host takes it; no new write is taken meanwhile
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ODC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? ODC_RESP_OKAY : ODC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Byte-lane merge of a host write into the control word
	wire [7:0] ctrl_lo = wr_strb[0] ? wr_data[7:0] : ctrl[7:0];
	wire [7:0] ctrl_hi = wr_strb[1] ? wr_data[15:8] : ctrl[15:8];
	wire [15:0] ctrl_wr = {ctrl_hi, ctrl_lo};

	// Loss clears enables whose keep-local bit is clear; loss wins over a same-cycle write
	wire [15:0] loss_mask;
	generate
		for (genvar m = 0; m < 16; m++) begin : g_mask
			if ((m % ODC_FLD_STRIDE == ODC_FLD_ENABLE) && (m / ODC_FLD_STRIDE < ODC_NUM_OUT)) begin : g_en
				// Keep bit of the same output decides whether its enable survives
				assign loss_mask[m] = ctrl[m-ODC_FLD_ENABLE+ODC_FLD_KEEP];
			end else begin : g_keep
				assign loss_mask[m] = 1'b1;
			end
		end
	endgenerate
	// Keep-local set leaves the enable alone, so counter drive continues
	// Unused bits are stored as written; the host keeps them zero
	wire [15:0] ctrl_base = wr_ctrl ? ctrl_wr : ctrl;
	wire [15:0] next_ctrl = loss_event ? (ctrl_base & loss_mask) : ctrl_base;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= ODC_CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// Output gating per output
	logic [ODC_NUM_OUT-1:0] next_out;
	generate
		for (genvar g = 0; g < ODC_NUM_OUT; g++) begin : g_out
			wire fo = ctrl[g*ODC_FLD_STRIDE+ODC_FLD_FORCE];
			wire en = ctrl[g*ODC_FLD_STRIDE+ODC_FLD_ENABLE];
			// Enable gates force and drive alike
			assign next_out[g] = en & (fo | counter_drive[g]);
		end
	endgenerate

	// Registered so the pins never glitch while the control word changes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_pin <= '0;
		end else begin
			out_pin <= next_out;
		end
	end

	// Read channel; status shows the synchronised loss level
	wire rd_ctrl = odc_hit_ctrl(s_axi_araddr);
	wire rd_stat = odc_hit_stat(s_axi_araddr);
	wire [31:0] stat_word = {29'h0, out_pin, loss_sync};
	wire [31:0] ctrl_word = {16'h0000, ctrl};
	wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h0000_0000);
	wire rd_ok = rd_ctrl | rd_stat;
	assign s_axi_arready = ~s_axi_rvalid;
	wire ar_take = s_axi_arvalid & s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Captured once, so data and response stand while rvalid waits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rdata <= '0;
			s_axi_rresp <= ODC_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? ODC_RESP_OKAY : ODC_RESP_SLVERR;
		end
	end
endmodule : odc_top

// ==== test/odc_drive_model.sv ====
// Partner model: compare and pulse drive source
module odc_drive_model (
	input logic aclk,
	input logic [1:0] pat,
	output logic [1:0] counter_drive
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge aclk) counter_drive <= pat;
endmodule : odc_drive_model

// ==== test/odc_properties.sv ====
// Checker for output gating and bus loss handling
module odc_props (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic bus_loss_pin,
	input logic [1:0] counter_drive,
	input logic [1:0] out_pin
);
	import odc_pkg::*;
	logic [2:0] s;
	logic [7:0] sh;
	wire ev = s[1] & ~s[2];
	wire [7:0] w = s_axi_awvalid & s_axi_awready ? s_axi_wdata[7:0] : sh;
	always_ff @(posedge aclk) s <= aresetn ? {s[1:0], bus_loss_pin} : 3'h0;
	// Loss clear wins over a write in the same cycle
	always_ff @(posedge aclk) sh <= aresetn ? w & ~{2'h0, ev & ~sh[6], 3'h0, ev & ~sh[2], 1'h0} : 8'h00;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence lost; ev; endsequence
	AST_FORCE0: assert property (sh[1] && sh[0] |=> out_pin[0]) else $error("force0");
	AST_OFF0: assert property (!sh[1] |=> !out_pin[0]) else $error("off0");
	AST_OFF1: assert property (!sh[5] |=> !out_pin[1]) else $error("off1");
	AST_DRV0: assert property (sh[1] && !sh[0] |=> out_pin[0] == $past(counter_drive[0])) else $error("drv0");
	AST_DRV1: assert property (sh[5] && !sh[4] |=> out_pin[1] == $past(counter_drive[1])) else $error("drv1");
	AST_KEEP0: assert property (lost ##0 (sh[2] && sh[1] && sh[0]) |-> ##2 out_pin[0]) else $error("keep0");
	AST_CLR1: assert property (lost ##0 (sh[5] && !sh[6]) |-> ##2 !out_pin[1]) else $error("clr1");
	AST_KEEP1: assert property (lost ##0 (sh[5] && sh[6] && !sh[4]) |-> ##2 out_pin[1] == $past(counter_drive[1])) else $error("keep1");
endmodule : odc_props
bind odc_top odc_props u_props (.*);

// ==== test/tb.sv ====
// Testbench for output drive control
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import odc_pkg::*;
	logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
	logic bus_loss_pin = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [1:0] pat = '0, counter_drive, out_pin, s_axi_bresp, s_axi_rresp;
	int failures = 0, samples_checked = 0, n = 0;
	// Address and data always offered and taken together
	wire s_axi_wvalid = s_axi_awvalid;
	always #2 aclk = ~aclk;
	odc_top dut (.*);
	odc_drive_model u_model (.*);
	task wrap_up;
		if (failures == 0 && samples_checked > 0 && n < 999)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task ck(string s, logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask : ck
	task guard;
		if (n >= 999) begin
			failures++;
			wrap_up;
		end
	endtask : guard
	task wr(logic [7:0] d);
		s_axi_wdata <= d;
		s_axi_awvalid <= '1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready) && ++n < 999);
		s_axi_awvalid <= '0;
		s_axi_bready <= '1;
		do @(posedge aclk); while (!s_axi_bvalid && ++n < 999);
		s_axi_bready <= '0;
		guard;
		ck("bresp", ODC_RESP_OKAY, s_axi_bresp);
	endtask : wr
	task rd(logic [3:0] a, logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= '1;
		do @(posedge aclk); while (!s_axi_arready && ++n < 999);
		s_axi_arvalid <= '0;
		s_axi_rready <= '1;
		do @(posedge aclk); while (!s_axi_rvalid && ++n < 999);
		s_axi_rready <= '0;
		guard;
		ck("rdata", e, s_axi_rdata);
		ck("rresp", (a == ODC_OFF_CTRL || a == ODC_OFF_STAT) ? ODC_RESP_OKAY : ODC_RESP_SLVERR, s_axi_rresp);
	endtask : rd
	task t_gate(logic [7:0] d, logic [1:0] p, e);
		wr(d);
		pat <= p;
		repeat (3) @(posedge aclk);
		ck("out_pin", e, out_pin);
	endtask : t_gate
	task t_loss(logic [7:0] d, e, logic [1:0] p);
		pat <= '1;
		wr(d);
		bus_loss_pin <= '1;
		repeat (6) @(posedge aclk);
		ck("out_pin", p, out_pin);
		rd(ODC_OFF_CTRL, e);
		rd(ODC_OFF_STAT, {29'h0, p, 1'b1});
		bus_loss_pin <= '0;
	endtask : t_loss
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= '1;
		rd(ODC_OFF_CTRL, ODC_CTRL_RESET);
		t_gate(8'h33, 2'h0, 2'h3);
		t_gate(8'h11, 2'h3, 2'h0);
		t_gate(8'h22, 2'h1, 2'h1);
		t_gate(8'h22, 2'h2, 2'h2);
		t_loss(8'h27, 8'h07, 2'h1);
		t_loss(8'h66, 8'h66, 2'h3);
		rd(4'h8, 32'h0);
		wrap_up;
	end
endmodule : tb
